// [hw/fhbp_port.sv]
// Framer host bus port: strap-selected parallel bus slave with register store
// Functional notes
// - Style strap high picks separate strobes, low picks data strobe plus direction.
// - In data-strobe style the shared strobe is an active-low data strobe.
// - In separate-strobe style the shared strobe is active-low read; device drives data.
// - Reads and writes are accepted only while chip select is low.
// - With chip select high the port idles and data pins float.
// - Device sits in reset while the reset pin is low.
// - Interrupt pin pulled low while an interrupt is pending, released otherwise.
// - Interrupt pin is open drain, low only; pull-up is external.
// - Interrupt works regardless of chip select.
// - Eight-bit three-state data bus, lowest line is the least significant bit.
// - In data-strobe style direction high means read, low means write.
// - In separate-strobe style the direction input is an active-low write strobe.
// - Five address inputs, lowest line least significant.
// - Highest data line carries the most significant bit.
`timescale 1ns/100ps
module fhbp_port (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        reset_pin_n,
  input  wire logic                        bus_style_select,
  input  wire logic                        chip_select_n,
  input  wire logic                        data_or_read_strobe_n,
  input  wire logic                        dir_or_write_strobe_n,
  input  wire logic [fhbp_pkg::ADDR_W-1:0] host_address_lines,
  input  wire logic [fhbp_pkg::NIB_W-1:0]  host_data_low_nibble_in,
  input  wire logic [fhbp_pkg::NIB_W-1:0]  host_data_high_nibble_in,
  output logic      [fhbp_pkg::NIB_W-1:0]  host_data_low_nibble_out,
  output logic      [fhbp_pkg::NIB_W-1:0]  host_data_high_nibble_out,
  output logic                             host_data_oe,
  output logic                             irq_out,
  output logic                             irq_oe,
  input  wire logic                        irq_pending,
  output logic                             dev_reset,
  output logic                             reg_wr_pulse,
  output logic      [fhbp_pkg::ADDR_W-1:0] reg_wr_addr,
  output logic      [fhbp_pkg::DATA_W-1:0] reg_wr_data,
  input  wire logic [fhbp_pkg::ADDR_W-1:0] core_rd_addr,
  output logic      [fhbp_pkg::DATA_W-1:0] core_rd_data
);
  import fhbp_pkg::*;

  // Synchroniser stages; the first stage is read only by the second
  logic [1:0]        rstn_s_r;
  logic [1:0]        style_s_r;
  logic [1:0]        cs_s_r;
  logic [1:0]        rs_s_r;
  logic [1:0]        ws_s_r;
  logic [ADDR_W-1:0] addr_m_r;
  logic [ADDR_W-1:0] addr_s_r;
  logic [DATA_W-1:0] din_m_r;
  logic [DATA_W-1:0] din_s_r;

  logic              dev_rst;
  logic              sel_q;
  logic              read_q;
  logic              write_q;
  fhbp_state_t       state_r;
  fhbp_state_t       state_nxt;
  logic              data_oe_r;
  logic [DATA_W-1:0] data_out_r;
  logic [DATA_W-1:0] rd_byte;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [DATA_W-1:0] wr_data_r;
  logic              wr_commit_r;
  logic              irq_oe_r;

  // Reset pin synchroniser; held in reset by the system reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      rstn_s_r <= SYNC_RST;
    end else begin
      rstn_s_r <= {rstn_s_r[0], reset_pin_n};
    end
  end

  // Pin reset low resets the access logic and store; the interrupt and the synchronisers keep running
  assign dev_rst   = rst | ~rstn_s_r[1];
  assign dev_reset = dev_rst;

  // Control pin synchronisers; strobes park at their idle high level
  always_ff @(posedge mclk) begin
    if (rst) begin
      style_s_r <= SYNC_RST;
      cs_s_r    <= SYNC_HI;
      rs_s_r    <= SYNC_HI;
      ws_s_r    <= SYNC_HI;
    end else begin
      style_s_r <= {style_s_r[0], bus_style_select};
      cs_s_r    <= {cs_s_r[0], chip_select_n};
      rs_s_r    <= {rs_s_r[0], data_or_read_strobe_n};
      ws_s_r    <= {ws_s_r[0], dir_or_write_strobe_n};
    end
  end

  // Address and data synchronisers; lowest pin is bit 0 of each word
  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_m_r <= ADDR_RST;
      addr_s_r <= ADDR_RST;
      din_m_r  <= DATA_RST;
      din_s_r  <= DATA_RST;
    end else begin
      addr_m_r <= host_address_lines;
      addr_s_r <= addr_m_r;
      din_m_r  <= {host_data_high_nibble_in, host_data_low_nibble_in};
      din_s_r  <= din_m_r;
    end
  end

  // Access qualification per bus style; select gates everything
  always_comb begin
    sel_q = ~cs_s_r[1];
    if (style_s_r[1] == STYLE_SEPARATE) begin
      read_q  = sel_q & ~rs_s_r[1];
      write_q = sel_q & ~ws_s_r[1] & rs_s_r[1];
    end else begin
      read_q  = sel_q & ~rs_s_r[1] & (ws_s_r[1] == DIR_READ);
      write_q = sel_q & ~rs_s_r[1] & (ws_s_r[1] != DIR_READ);
    end
  end

  // Sequencer: a write commits when its qualification ends, so the
  // byte taken is the last one the host held during the strobe
  always_comb begin
    case (state_r)
      FHBP_IDLE: begin
        if (read_q) begin
          state_nxt = FHBP_READ;
        end else if (write_q) begin
          state_nxt = FHBP_WRITE;
        end else begin
          state_nxt = FHBP_IDLE;
        end
      end
      // A read that follows straight on from a write (or the reverse) is
      // taken at once; idle and read test the read first, write tests the write first
      FHBP_READ: begin
        if (read_q) begin
          state_nxt = FHBP_READ;
        end else if (write_q) begin
          state_nxt = FHBP_WRITE;
        end else begin
          state_nxt = FHBP_IDLE;
        end
      end
      FHBP_WRITE: begin
        if (write_q) begin
          state_nxt = FHBP_WRITE;
        end else if (read_q) begin
          state_nxt = FHBP_READ;
        end else begin
          state_nxt = FHBP_IDLE;
        end
      end
      default:    state_nxt = FHBP_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (dev_rst) begin
      state_r <= FHBP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Write capture and commit; address and data follow the bus while the strobe is low and freeze when it ends
  always_ff @(posedge mclk) begin
    if (dev_rst) begin
      wr_addr_r   <= ADDR_RST;
      wr_data_r   <= DATA_RST;
      wr_commit_r <= 1'b0;
    end else begin
      wr_commit_r <= (state_r == FHBP_WRITE) && !write_q;
      if (state_r == FHBP_WRITE && write_q) begin
        wr_addr_r <= addr_s_r;
        wr_data_r <= din_s_r;
      end
    end
  end

  assign reg_wr_pulse = wr_commit_r;
  assign reg_wr_addr  = wr_addr_r;
  assign reg_wr_data  = wr_data_r;

  fhbp_regmem u_mem (
    .mclk      (mclk),
    .rst       (dev_rst),
    .wr_en     (wr_commit_r),
    .wr_addr   (wr_addr_r),
    .wr_data   (wr_data_r),
    .rd_addr_a (addr_s_r),
    .rd_data_a (rd_byte),
    .rd_addr_b (core_rd_addr),
    .rd_data_b (core_rd_data)
  );

  // Read drive: enable only in a qualified read, so a deselected
  // port never fights the bus; data comes from a flop
  always_ff @(posedge mclk) begin
    if (dev_rst) begin
      data_oe_r  <= 1'b0;
      data_out_r <= DATA_RST;
    end else begin
      data_oe_r  <= (state_nxt == FHBP_READ);
      data_out_r <= rd_byte;
    end
  end

  assign host_data_oe              = data_oe_r;
  assign host_data_low_nibble_out  = data_out_r[NIB_W-1:0];
  assign host_data_high_nibble_out = data_out_r[DATA_W-1:NIB_W];

  // Interrupt: follows pending status alone, select plays no part;
  // kept alive through a pin reset since it is not an access
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_oe_r <= 1'b0;
    end else begin
      irq_oe_r <= irq_pending;
    end
  end

  assign irq_oe  = irq_oe_r;
  assign irq_out = IRQ_DRIVE_LEVEL;

  // Checks
  cs_idle_float_a: assert property (@(posedge mclk) disable iff (rst)
    !sel_q |=> !host_data_oe)
    else $error("data bus driven while deselected");

  sep_read_drive_a: assert property (@(posedge mclk) disable iff (dev_rst)
    (style_s_r[1] && sel_q && !rs_s_r[1]) |=> host_data_oe)
    else $error("separate-strobe read not driven");

  ds_read_drive_a: assert property (@(posedge mclk) disable iff (dev_rst)
    (!style_s_r[1] && sel_q && !rs_s_r[1] && ws_s_r[1]) |=> host_data_oe)
    else $error("data-strobe read not driven");

  ds_write_nodrive_a: assert property (@(posedge mclk) disable iff (dev_rst)
    (!style_s_r[1] && !ws_s_r[1] && state_r == FHBP_IDLE) |=> !host_data_oe)
    else $error("data bus driven during write direction");

  write_commit_a: assert property (@(posedge mclk) disable iff (dev_rst)
    (state_r == FHBP_WRITE && !write_q) |=> (reg_wr_pulse && reg_wr_data == $past(wr_data_r)))
    else $error("write not committed at strobe end");

  read_data_path_a: assert property (@(posedge mclk) disable iff (dev_rst)
    host_data_oe |-> data_out_r == $past(u_mem.mem_r[addr_s_r], 2))
    else $error("read byte not from addressed register");

  pin_reset_idle_a: assert property (@(posedge mclk) disable iff (rst)
    !rstn_s_r[1] |=> (state_r == FHBP_IDLE && !host_data_oe && !reg_wr_pulse))
    else $error("port active under pin reset");

  irq_follow_a: assert property (@(posedge mclk) disable iff (rst)
    irq_pending |=> irq_oe ##0 irq_out == IRQ_DRIVE_LEVEL)
    else $error("interrupt not pulled low when pending");

  irq_release_a: assert property (@(posedge mclk) disable iff (rst)
    !irq_pending |=> !irq_oe)
    else $error("interrupt held low without pending");

  // Sequencer entry: a deselected port never leaves idle, and each
  // qualified strobe starts the access its bus style calls for
  desel_stay_idle_a: assert property (@(posedge mclk) disable iff (dev_rst)
    (cs_s_r[1] && state_r == FHBP_IDLE) |=> state_r == FHBP_IDLE)
    else $error("deselected port left idle");

  sep_write_start_a: assert property (@(posedge mclk) disable iff (dev_rst)
    (style_s_r[1] && sel_q && rs_s_r[1] && !ws_s_r[1] && state_r == FHBP_IDLE)
    |=> state_r == FHBP_WRITE)
    else $error("separate-strobe write not started");

  ds_write_start_a: assert property (@(posedge mclk) disable iff (dev_rst)
    (!style_s_r[1] && sel_q && !rs_s_r[1] && !ws_s_r[1] && state_r == FHBP_IDLE)
    |=> state_r == FHBP_WRITE)
    else $error("data-strobe write not started");

  write_capture_a: assert property (@(posedge mclk) disable iff (dev_rst)
    (state_r == FHBP_WRITE && write_q) |=>
    (wr_data_r == $past(din_s_r) && wr_addr_r == $past(addr_s_r)))
    else $error("write byte or address not captured");

  // Drive and pulse shape: the bus is driven only in a read, and a
  // commit is a single cycle so the store takes each byte once
  oe_in_read_a: assert property (@(posedge mclk) disable iff (dev_rst)
    host_data_oe |-> state_r == FHBP_READ)
    else $error("data bus driven outside a read");

  wr_pulse_single_a: assert property (@(posedge mclk) disable iff (dev_rst)
    reg_wr_pulse |=> !reg_wr_pulse)
    else $error("write commit longer than one cycle");

  read_seen_c: cover property (@(posedge mclk) disable iff (dev_rst)
    state_r == FHBP_READ ##1 state_r == FHBP_IDLE);
  write_seen_c: cover property (@(posedge mclk) disable iff (dev_rst)
    reg_wr_pulse);
  irq_desel_c: cover property (@(posedge mclk) disable iff (rst)
    irq_oe && cs_s_r[1]);
  style_swap_c: cover property (@(posedge mclk) disable iff (rst)
    $changed(style_s_r[1]));
  ds_read_c: cover property (@(posedge mclk) disable iff (dev_rst)
    !style_s_r[1] && host_data_oe);

endmodule : fhbp_port

// [hw/fhbp_pkg.sv]
// Shared constants and types of the framer host bus port
package fhbp_pkg;

  // Bus widths
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int NIB_W  = 4;
  localparam int REG_NUM = 32;

  // Level of the style strap that picks separate read and write strobes
  localparam logic STYLE_SEPARATE = 1'b1;
  // Level of the direction input that means a read in the data-strobe style
  localparam logic DIR_READ = 1'b1;

  // Reset values
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
  localparam logic [1:0]        SYNC_RST = 2'h0;
  localparam logic [1:0]        SYNC_HI  = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_ZERO_SYNC = 5'h00;

  // Open-drain interrupt drives low only
  localparam logic IRQ_DRIVE_LEVEL = 1'b0;

  // Access sequencer states, one-hot
  typedef enum logic [2:0] {
    FHBP_IDLE  = 3'b001,
    FHBP_READ  = 3'b010,
    FHBP_WRITE = 3'b100
  } fhbp_state_t;

endpackage : fhbp_pkg

// [hw/fhbp_regmem.sv]
// Register byte store of the host port: one write port, two registered read ports
`timescale 1ns/100ps
module fhbp_regmem (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        wr_en,
  input  wire logic [fhbp_pkg::ADDR_W-1:0] wr_addr,
  input  wire logic [fhbp_pkg::DATA_W-1:0] wr_data,
  input  wire logic [fhbp_pkg::ADDR_W-1:0] rd_addr_a,
  output logic      [fhbp_pkg::DATA_W-1:0] rd_data_a,
  input  wire logic [fhbp_pkg::ADDR_W-1:0] rd_addr_b,
  output logic      [fhbp_pkg::DATA_W-1:0] rd_data_b
);
  import fhbp_pkg::*;

  logic [DATA_W-1:0] mem_r [REG_NUM];

  // Storage; cleared by reset so every register reads a known value
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < REG_NUM; i++) begin
        mem_r[i] <= DATA_RST;
      end
    end else if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // Registered read ports; no write bypass, a read sees the old byte
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_data_a <= DATA_RST;
      rd_data_b <= DATA_RST;
    end else begin
      rd_data_a <= mem_r[rd_addr_a];
      rd_data_b <= mem_r[rd_addr_b];
    end
  end

endmodule : fhbp_regmem

// [verif/fhbp_host_model.sv]
// Host processor model on the parallel bus of the framer host port
`timescale 1ns/100ps
module fhbp_host_model (
  input  wire logic                        mclk,
  input  wire logic                        bus_style_select,
  output logic                             chip_select_n,
  output logic                             data_or_read_strobe_n,
  output logic                             dir_or_write_strobe_n,
  output logic      [fhbp_pkg::ADDR_W-1:0] host_address_lines,
  output logic      [fhbp_pkg::NIB_W-1:0]  host_data_low_nibble_in,
  output logic      [fhbp_pkg::NIB_W-1:0]  host_data_high_nibble_in,
  input  wire logic [fhbp_pkg::NIB_W-1:0]  host_data_low_nibble_out,
  input  wire logic [fhbp_pkg::NIB_W-1:0]  host_data_high_nibble_out,
  input  wire logic                        host_data_oe
);
  import fhbp_pkg::*;
  logic [DATA_W-1:0] drv_r;
  logic              drv_en_r;
  // Bus resolution; no pull on data, so a floating bus shows the inverse of the last drive
  assign {host_data_high_nibble_in, host_data_low_nibble_in} = host_data_oe ?
    {host_data_high_nibble_out, host_data_low_nibble_out} : (drv_en_r ? drv_r : ~drv_r);
  // Idle bus
  initial begin
    chip_select_n = 1'b1;
    data_or_read_strobe_n = 1'b1;
    dir_or_write_strobe_n = 1'b1;
    host_address_lines = ADDR_RST;
    drv_r = DATA_RST;
    drv_en_r = 1'b0;
  end
  // One access, strobe held 8 cycles; address and data held 3 cycles past the strobe
  task automatic access(input logic sel, input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
                        output logic oe_seen);
    @(posedge mclk);
    #1;
    chip_select_n = !sel;
    host_address_lines = a;
    drv_r = d;
    drv_en_r = wr;
    dir_or_write_strobe_n = !wr;
    data_or_read_strobe_n = bus_style_select ? wr : 1'b0;
    repeat (8) @(posedge mclk);
    q = {host_data_high_nibble_in, host_data_low_nibble_in};
    oe_seen = host_data_oe;
    #1;
    data_or_read_strobe_n = 1'b1;
    dir_or_write_strobe_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chip_select_n = 1'b1;
    drv_en_r = 1'b0;
    repeat (6) @(posedge mclk);
  endtask : access
endmodule : fhbp_host_model

// [verif/fhbp_port_tb_top.sv]
// Self-checking bench of the framer host bus port
`timescale 1ns/100ps
module fhbp_port_tb_top;
  import fhbp_pkg::*;
  logic mclk = 1'b0;
  logic rst, reset_pin_n, style, irq_pending, cs_n, ds_n, dir_n, oe, irq_out, irq_oe, dev_rst;
  logic wr_pulse;
  logic [NIB_W-1:0]  dlo_i, dhi_i, dlo_o, dhi_o;
  logic [ADDR_W-1:0] addr, wa, core_a, last_wa;
  logic [DATA_W-1:0] wd, core_d, last_wd, q;
  logic oe_seen;
  int err_total = 0, cmp_count = 0, wr_count = 0, cycles = 0;
  wire irq_wire = irq_oe ? irq_out : 1'b1; // board pull-up

  always #2.5 mclk = ~mclk;

  fhbp_host_model u_host (.mclk(mclk), .bus_style_select(style), .chip_select_n(cs_n),
    .data_or_read_strobe_n(ds_n), .dir_or_write_strobe_n(dir_n), .host_address_lines(addr),
    .host_data_low_nibble_in(dlo_i), .host_data_high_nibble_in(dhi_i),
    .host_data_low_nibble_out(dlo_o), .host_data_high_nibble_out(dhi_o), .host_data_oe(oe));
  fhbp_port u_dut (.mclk(mclk), .rst(rst), .reset_pin_n(reset_pin_n), .bus_style_select(style),
    .chip_select_n(cs_n), .data_or_read_strobe_n(ds_n), .dir_or_write_strobe_n(dir_n),
    .host_address_lines(addr), .host_data_low_nibble_in(dlo_i),
    .host_data_high_nibble_in(dhi_i), .host_data_low_nibble_out(dlo_o),
    .host_data_high_nibble_out(dhi_o), .host_data_oe(oe), .irq_out(irq_out), .irq_oe(irq_oe),
    .irq_pending(irq_pending), .dev_reset(dev_rst), .reg_wr_pulse(wr_pulse),
    .reg_wr_addr(wa), .reg_wr_data(wd), .core_rd_addr(core_a), .core_rd_data(core_d));

  // Committed writes and the hang limit; the run needs under 600 cycles
  always @(posedge mclk) begin
    cycles++;
    if (wr_pulse === 1'b1) begin
      wr_count++;
      last_wa = wa;
      last_wd = wd;
    end
    if (cycles == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic check(input string name, input logic [DATA_W-1:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // Write then read back in both bus styles, with the extreme data and address bits
  task automatic sc_styles();
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    int n;
    for (int s = 0; s < 2; s++) begin
      #1;
      style = s[0];
      a = s ? 5'h10 : 5'h01;
      d = s ? 8'h80 : 8'h01;
      n = wr_count;
      repeat (4) @(posedge mclk);
      u_host.access(1'b1, 1'b1, a, d, q, oe_seen);
      check("wr count", 8'(wr_count - n), 8'h01);
      check("wr addr", {3'h0, last_wa}, {3'h0, a});
      check("wr data", last_wd, d);
      u_host.access(1'b1, 1'b0, a, 8'h00, q, oe_seen);
      check("rd oe", {7'h00, oe_seen}, 8'h01);
      check("rd data", q, d);
      check("idle oe", {7'h00, oe}, 8'h00);
      #1 core_a = a;
      repeat (2) @(posedge mclk);
      check("core data", core_d, d);
    end
  endtask : sc_styles

  // Accesses with select high are ignored
  task automatic sc_deselect();
    int n;
    n = wr_count;
    u_host.access(1'b0, 1'b1, 5'h10, 8'h5a, q, oe_seen);
    check("desel wr", 8'(wr_count - n), 8'h00);
    u_host.access(1'b0, 1'b0, 5'h10, 8'h00, q, oe_seen);
    check("desel oe", {7'h00, oe_seen}, 8'h00);
    u_host.access(1'b1, 1'b0, 5'h10, 8'h00, q, oe_seen);
    check("kept data", q, 8'h80);
  endtask : sc_deselect

  // Interrupt follows pending one edge later, with select high
  task automatic sc_irq();
    #1;
    for (int v = 1; v >= 0; v--) begin
      irq_pending = v[0];
      @(posedge mclk);
      #1;
      check("irq wire", {7'h00, irq_wire}, {7'h00, !v[0]});
      check("irq level", {7'h00, irq_out}, {7'h00, IRQ_DRIVE_LEVEL});
    end
  endtask : sc_irq

  // Pin reset of 200 cycles clears the store
  task automatic sc_pin_reset();
    reset_pin_n = 1'b0;
    repeat (200) @(posedge mclk);
    #1;
    check("dev reset on", {7'h00, dev_rst}, 8'h01);
    reset_pin_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    check("dev reset off", {7'h00, dev_rst}, 8'h00);
    u_host.access(1'b1, 1'b0, 5'h10, 8'h00, q, oe_seen);
    check("cleared data", q, DATA_RST);
  endtask : sc_pin_reset

  initial begin
    rst = 1'b1;
    reset_pin_n = 1'b0; // pin pulse after power-up
    style = 1'b1;
    irq_pending = 1'b0;
    core_a = ADDR_RST;
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (200) @(posedge mclk);
    #1 reset_pin_n = 1'b1;
    repeat (4) @(posedge mclk);
    sc_styles();
    sc_deselect();
    sc_irq();
    sc_pin_reset();
    wrap_up();
  end
endmodule : fhbp_port_tb_top
